// *** core/phycfg_pkg.sv ***
package phycfg_pkg;
  localparam int STRAP_W = 4;
  localparam int PAIRS = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [4:0] ADDR_RESET = 5'h00;
  localparam int ADDR_LSB = 1;
  localparam logic REF_SEL_RESET = 1'b0;
  localparam int REF_DIV_FAST = 2;
  localparam int REF_DIV_SLOW = 8;
  localparam int REF_CNT_W = 4;
  localparam logic [REF_CNT_W-1:0] REF_CNT_RESET = 4'h0;
  localparam int MDC_MAX_KHZ = 2500;
  // pair lane codes: 0 idle, 1 BI_DA, 2 BI_DB, 3 BI_DC, 4 BI_DD, 5 transmit, 6 receive
  typedef enum logic [2:0] {
    PCFG_IDLE, PCFG_BIDA, PCFG_BIDB, PCFG_BIDC, PCFG_BIDD, PCFG_TX, PCFG_RX
  } phycfg_lane_t;
  typedef enum logic [1:0] {PCFG_SPD10, PCFG_SPD100, PCFG_SPD1000} phycfg_speed_t;
endpackage : phycfg_pkg

// *** core/phycfg_sync.sv ***
`timescale 1ns/1ps
module phycfg_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rstN,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } phycfg_sync_t;
  phycfg_sync_t s_q, s_d;
  always_comb begin
    s_d.meta = asyncIn;
    s_d.stable = s_q.meta;
  end
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign syncOut = s_q.stable;
endmodule : phycfg_sync

// *** core/phycfg_mdio_pad.sv ***
`timescale 1ns/1ps
module phycfg_mdio_pad (
  input wire logic mdcClk,
  input wire logic rstN,
  input wire logic readDrive,
  input wire logic readBit,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic mdioSample
);
  typedef struct packed {
    logic oe;
    logic dout;
    logic din;
  } phycfg_pad_t;
  phycfg_pad_t p_q, p_d;
  always_comb begin
    p_d = p_q;
    p_d.din = mdioIn;
    p_d.oe = readDrive;
    p_d.dout = readDrive ? readBit : 1'b0;
  end
  // state survives any stop of the management clock
  always_ff @(posedge mdcClk or negedge rstN) begin
    if (!rstN) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end
  assign mdioOut = p_q.dout;
  assign mdioOe = p_q.oe;
  assign mdioSample = p_q.din;
  oe_release_a: assert property (@(posedge mdcClk) disable iff (!rstN)
    !readDrive |=> !mdioOe) else $error("mdio not released");
endmodule : phycfg_mdio_pad

// *** core/phycfg_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - management clock may stop between transfers; state is kept.
// - management data line is two-way, driven and sampled on management clock.
// - straps captured on power-good rise, reset release or sleep release.
// - strap index 0..3 become management address bits 1..4.
// - gigabit: pair 0 DA/DB, pair 1 DB/DA for MDI/MDIX.
// - gigabit: pair 2 DC/DD, pair 3 DD/DC; unused at 10/100.
// - 10/100: pair 0 transmit/receive, pair 1 receive/transmit for MDI/MDIX.
// - link pin sampled at power-good rise selects reference clock rate; chip reset low forces the slow rate until the next rise.
// - after power-good, link pin drives link-up status, but drives low while asleep or in chip reset.
// - power-good low holds all logic except the strap address in reset.
// - chip reset low resets all logic except the strap address and the link pin enable.
// - sleep powers down phy and host link logic.
module phycfg_top (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic mdcClk,
  input wire logic power_good_in,
  input wire logic chip_reset_in_n,
  input wire logic sleep_powerdown_in,
  input wire logic [phycfg_pkg::STRAP_W-1:0] addrStrapIn,
  input wire logic linkPinIn,
  output logic linkPinOut,
  output logic linkPinOe,
  input wire logic mdioIn,
  output logic mdioOut,
  output logic mdioOe,
  output logic mdioSample,
  input wire logic mdioReadDrive,
  input wire logic mdioReadBit,
  input wire logic linkUp,
  input wire logic mdixSel,
  input wire phycfg_pkg::phycfg_speed_t speedSel,
  output logic [4:0] mgmtAddr,
  output logic refClkFastSel,
  output logic host_ref_clock_out,
  output logic phyPowerDown,
  output phycfg_pkg::phycfg_lane_t [phycfg_pkg::PAIRS-1:0] pairLane
);
  logic pgSync;
  logic rstSync;
  logic slpSync;
  logic linkSync;
  logic [phycfg_pkg::STRAP_W-1:0] strapSync;
  logic mdcRstN;

  phycfg_sync #(.WIDTH(4 + phycfg_pkg::STRAP_W)) u_sync (
    .clk(core_clk),
    .rstN(arst_n),
    .asyncIn({power_good_in, chip_reset_in_n, sleep_powerdown_in, linkPinIn, addrStrapIn}),
    .syncOut({pgSync, rstSync, slpSync, linkSync, strapSync})
  );

  typedef struct packed {
    logic pgPrev;
    logic rstPrev;
    logic slpPrev;
    logic [4:0] addr;
    logic refFast;
    logic linkDrv;
    logic linkVal;
    logic pwrDown;
    logic [phycfg_pkg::REF_CNT_W-1:0] refCnt;
    logic refClk;
    logic mdcRun;
    phycfg_pkg::phycfg_lane_t [phycfg_pkg::PAIRS-1:0] lanes;
  } phycfg_state_t;

  phycfg_state_t st_q, st_d;

  function automatic phycfg_pkg::phycfg_lane_t laneOf(
    input int pair,
    input logic mdix,
    input phycfg_pkg::phycfg_speed_t spd
  );
    phycfg_pkg::phycfg_lane_t l;
    l = phycfg_pkg::PCFG_IDLE;
    if (spd == phycfg_pkg::PCFG_SPD1000) begin
      unique case (pair)
        0: l = mdix ? phycfg_pkg::PCFG_BIDB : phycfg_pkg::PCFG_BIDA;
        1: l = mdix ? phycfg_pkg::PCFG_BIDA : phycfg_pkg::PCFG_BIDB;
        2: l = mdix ? phycfg_pkg::PCFG_BIDD : phycfg_pkg::PCFG_BIDC;
        default: l = mdix ? phycfg_pkg::PCFG_BIDC : phycfg_pkg::PCFG_BIDD;
      endcase
    end else begin
      unique case (pair)
        0: l = mdix ? phycfg_pkg::PCFG_RX : phycfg_pkg::PCFG_TX;
        1: l = mdix ? phycfg_pkg::PCFG_TX : phycfg_pkg::PCFG_RX;
        default: l = phycfg_pkg::PCFG_IDLE;
      endcase
    end
    return l;
  endfunction : laneOf

  logic capture;
  logic inReset;
  logic [phycfg_pkg::REF_CNT_W-1:0] refDiv;
  // high while the port is neither reset nor asleep
  logic laneLive;

  always_comb begin
    inReset = !pgSync || !rstSync;
    laneLive = !(slpSync || inReset);
    capture = (pgSync && !st_q.pgPrev) || (rstSync && !st_q.rstPrev)
      || (!slpSync && st_q.slpPrev);
    refDiv = st_q.refFast ? phycfg_pkg::REF_CNT_W'(phycfg_pkg::REF_DIV_FAST - 1)
      : phycfg_pkg::REF_CNT_W'(phycfg_pkg::REF_DIV_SLOW - 1);
    st_d = st_q;
    st_d.pgPrev = pgSync;
    st_d.rstPrev = rstSync;
    st_d.slpPrev = slpSync;
    if (capture) begin
      st_d.addr = {strapSync, 1'b0};
    end
    if (pgSync && !st_q.pgPrev) begin
      st_d.refFast = linkSync;
    end
    st_d.linkDrv = pgSync;
    st_d.linkVal = pgSync && linkUp && !slpSync;
    st_d.pwrDown = slpSync || inReset;
    st_d.mdcRun = !(slpSync || inReset);
    for (int i = 0; i < phycfg_pkg::PAIRS; i++) begin
      st_d.lanes[i] = st_d.pwrDown ? phycfg_pkg::PCFG_IDLE : laneOf(i, mdixSel, speedSel);
    end
    if (st_d.pwrDown) begin
      st_d.refCnt = phycfg_pkg::REF_CNT_RESET;
      st_d.refClk = 1'b0;
    end else if (st_q.refCnt >= refDiv) begin
      st_d.refCnt = phycfg_pkg::REF_CNT_RESET;
      st_d.refClk = !st_q.refClk;
    end else begin
      st_d.refCnt = st_q.refCnt + phycfg_pkg::REF_CNT_W'(1);
    end
    if (inReset) begin
      st_d.refFast = phycfg_pkg::REF_SEL_RESET;
      st_d.linkVal = 1'b0;
      if (!capture) begin
        st_d.addr = st_q.addr;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  phycfg_sync #(.WIDTH(1)) u_mdc_rst (
    .clk(mdcClk),
    .rstN(arst_n),
    .asyncIn(st_q.mdcRun),
    .syncOut(mdcRstN)
  );

  phycfg_mdio_pad u_mdio (
    .mdcClk(mdcClk),
    .rstN(mdcRstN),
    .readDrive(mdioReadDrive),
    .readBit(mdioReadBit),
    .mdioIn(mdioIn),
    .mdioOut(mdioOut),
    .mdioOe(mdioOe),
    .mdioSample(mdioSample)
  );

  assign mgmtAddr = st_q.addr;
  assign refClkFastSel = st_q.refFast;
  assign host_ref_clock_out = st_q.refClk;
  assign linkPinOe = st_q.linkDrv;
  assign linkPinOut = st_q.linkVal;
  assign phyPowerDown = st_q.pwrDown;
  assign pairLane = st_q.lanes;

  // strap capture and address
  strap_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    capture |=> mgmtAddr == {$past(strapSync), 1'b0})
    else $error("strap not captured");

  addr_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !capture |=> $stable(mgmtAddr))
    else $error("address changed");

  addr_bit0_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |-> mgmtAddr[0] == 1'b0)
    else $error("address bit 0 set");

  pg_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(pgSync) |-> capture)
    else $error("no capture on power-good");

  rst_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(rstSync) |-> capture)
    else $error("no capture on reset release");

  slp_capture_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $fell(slpSync) |-> capture)
    else $error("no capture on sleep release");

  // link pin and reference select
  link_drive_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    pgSync |=> linkPinOe)
    else $error("link pin not driven");

  link_float_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pgSync |=> !linkPinOe)
    else $error("link pin driven in reset");

  link_follow_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive |=> linkPinOut == $past(linkUp))
    else $error("link status wrong");

  link_off_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    slpSync |=> !linkPinOut)
    else $error("link shown while asleep");

  ref_select_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(pgSync) && rstSync |=> refClkFastSel == $past(linkSync))
    else $error("ref select");

  ref_hold_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    pgSync && rstSync && !$rose(pgSync) |=> $stable(refClkFastSel))
    else $error("ref select moved");

  ref_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pgSync || !rstSync |=> !refClkFastSel)
    else $error("ref select kept in reset");

  ref_wait_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_d.pwrDown && st_q.refCnt < refDiv |=> $stable(host_ref_clock_out))
    else $error("ref clock early edge");

  ref_flip_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !st_d.pwrDown && st_q.refCnt >= refDiv |=> $changed(host_ref_clock_out))
    else $error("ref clock missed edge");

  // reset and power down
  pg_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !pgSync |=> phyPowerDown && !linkPinOut)
    else $error("pg reset");

  chip_reset_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !rstSync |=> phyPowerDown && !host_ref_clock_out)
    else $error("chip reset");

  sleep_down_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    slpSync |=> phyPowerDown ##0 pairLane == '0)
    else $error("sleep power");

  power_up_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive |=> !phyPowerDown)
    else $error("powered down while live");

  lane_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phyPowerDown |-> pairLane == '0)
    else $error("lanes active while down");

  ref_quiet_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    phyPowerDown |-> !host_ref_clock_out)
    else $error("ref clock while down");

  // media pair mapping
  giga_map_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel == phycfg_pkg::PCFG_SPD1000 && mdixSel
    |=> pairLane[0] == phycfg_pkg::PCFG_BIDB && pairLane[3] == phycfg_pkg::PCFG_BIDC)
    else $error("gigabit map");

  giga_mdix_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel == phycfg_pkg::PCFG_SPD1000 && mdixSel
    |=> pairLane[1] == phycfg_pkg::PCFG_BIDA && pairLane[2] == phycfg_pkg::PCFG_BIDD)
    else $error("gigabit crossed map");

  giga_mdi_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel == phycfg_pkg::PCFG_SPD1000 && !mdixSel
    |=> pairLane[0] == phycfg_pkg::PCFG_BIDA && pairLane[1] == phycfg_pkg::PCFG_BIDB)
    else $error("gigabit straight map");

  giga_upper_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel == phycfg_pkg::PCFG_SPD1000 && !mdixSel
    |=> pairLane[2] == phycfg_pkg::PCFG_BIDC && pairLane[3] == phycfg_pkg::PCFG_BIDD)
    else $error("gigabit upper map");

  fast_map_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel != phycfg_pkg::PCFG_SPD1000 && !mdixSel
    |=> pairLane[0] == phycfg_pkg::PCFG_TX && pairLane[2] == phycfg_pkg::PCFG_IDLE)
    else $error("10/100 map");

  fast_rx_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel != phycfg_pkg::PCFG_SPD1000 && !mdixSel
    |=> pairLane[1] == phycfg_pkg::PCFG_RX && pairLane[3] == phycfg_pkg::PCFG_IDLE)
    else $error("10/100 receive map");

  fast_mdix_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel != phycfg_pkg::PCFG_SPD1000 && mdixSel
    |=> pairLane[0] == phycfg_pkg::PCFG_RX && pairLane[1] == phycfg_pkg::PCFG_TX)
    else $error("10/100 crossed map");

  fast_unused_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    laneLive && speedSel != phycfg_pkg::PCFG_SPD1000 && mdixSel
    |=> pairLane[2] == phycfg_pkg::PCFG_IDLE && pairLane[3] == phycfg_pkg::PCFG_IDLE)
    else $error("10/100 upper pairs used");
endmodule : phycfg_top

// *** tb/phycfg_host_model.sv ***
`timescale 1ns/1ps
module phycfg_host_model (
  input wire logic runEn,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output logic mdcClk,
  output logic mdioIn
);
  initial mdcClk = 1'b0;
  // clock parked low between transfers, never above the management limit
  always #(500000.0 / phycfg_pkg::MDC_MAX_KHZ) mdcClk = runEn ? ~mdcClk : 1'b0;
  // released line floats to the pull-up
  assign mdioIn = mdioOe ? mdioOut : 1'b1;
endmodule : phycfg_host_model

// *** tb/phycfg_top_test.sv ***
`timescale 1ns/1ps
module phycfg_top_test;
  logic core_clk, arst_n, mdcClk, pwrGood, rstInN, sleepIn, linkPinIn, linkPinOut, linkPinOe;
  logic mdioIn, mdioOut, mdioOe, mdioSample, rdDrive, rdBit, linkUp, mdixSel;
  logic refFast, refClk, pwrDown, runEn, linkStrap;
  logic [3:0] straps;
  logic [4:0] mgmtAddr;
  phycfg_pkg::phycfg_speed_t speedSel;
  phycfg_pkg::phycfg_lane_t [phycfg_pkg::PAIRS-1:0] pairLane;
  int errCount;
  int comparisons;
  int flips;

  initial core_clk = 1'b0;
  always #2.5 core_clk = ~core_clk;
  // strap level shows only while the device does not drive the pin
  assign linkPinIn = linkPinOe ? linkPinOut : linkStrap;

  phycfg_top phycfg_top_inst (.core_clk(core_clk), .arst_n(arst_n), .mdcClk(mdcClk),
    .power_good_in(pwrGood), .chip_reset_in_n(rstInN), .sleep_powerdown_in(sleepIn),
    .addrStrapIn(straps), .linkPinIn(linkPinIn), .linkPinOut(linkPinOut),
    .linkPinOe(linkPinOe), .mdioIn(mdioIn), .mdioOut(mdioOut), .mdioOe(mdioOe),
    .mdioSample(mdioSample), .mdioReadDrive(rdDrive), .mdioReadBit(rdBit),
    .linkUp(linkUp), .mdixSel(mdixSel), .speedSel(speedSel), .mgmtAddr(mgmtAddr),
    .refClkFastSel(refFast), .host_ref_clock_out(refClk), .phyPowerDown(pwrDown),
    .pairLane(pairLane));
  phycfg_host_model phycfg_host_model_inst (.runEn(runEn), .mdioOut(mdioOut),
    .mdioOe(mdioOe), .mdcClk(mdcClk), .mdioIn(mdioIn));

  task chk(input logic [11:0] got, input logic [11:0] exp);
    comparisons++;
    if (got !== exp) begin
      errCount++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task step(input int n);
    repeat (n) @(negedge core_clk);
  endtask : step

  task countFlips(input int n, output int cnt);
    logic last;
    cnt = 0;
    last = refClk;
    repeat (n) begin
      @(negedge core_clk);
      if (refClk !== last) cnt++;
      last = refClk;
    end
  endtask : countFlips

  function logic [11:0] lanes(input int spd, input logic x);
    if (spd == 2)
      return x ? {phycfg_pkg::PCFG_BIDC, phycfg_pkg::PCFG_BIDD, phycfg_pkg::PCFG_BIDA,
        phycfg_pkg::PCFG_BIDB} : {phycfg_pkg::PCFG_BIDD, phycfg_pkg::PCFG_BIDC,
        phycfg_pkg::PCFG_BIDB, phycfg_pkg::PCFG_BIDA};
    return x ? {6'h00, phycfg_pkg::PCFG_TX, phycfg_pkg::PCFG_RX}
      : {6'h00, phycfg_pkg::PCFG_RX, phycfg_pkg::PCFG_TX};
  endfunction : lanes

  task closeOut;
    $display("errors %0d comparisons %0d", errCount, comparisons);
    if (errCount == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : closeOut

  initial begin
    #40000;
    errCount++;
    closeOut;
  end

  initial begin
    errCount = 0;
    comparisons = 0;
    arst_n = 1'b0;
    pwrGood = 1'b0;
    rstInN = 1'b1;
    sleepIn = 1'b0;
    straps = 4'hA;
    linkStrap = 1'b1;
    rdDrive = 1'b0;
    rdBit = 1'b0;
    linkUp = 1'b0;
    mdixSel = 1'b0;
    speedSel = phycfg_pkg::PCFG_SPD1000;
    runEn = 1'b0;
    step(10);
    arst_n = 1'b1;
    step(4);
    chk(refFast, 12'h000);
    chk(linkPinOe, 12'h000);
    pwrGood = 1'b1;
    step(8);
    chk(mgmtAddr, 12'h014);
    chk(refFast, 12'h001);
    chk(linkPinOe, 12'h001);
    countFlips(16, flips);
    chk(flips[11:0], 12'(16 / phycfg_pkg::REF_DIV_FAST));
    linkUp = 1'b1;
    step(6);
    chk(linkPinIn, 12'h001);
    linkUp = 1'b0;
    step(6);
    chk(linkPinIn, 12'h000);
    straps = 4'h5;
    rstInN = 1'b0;
    linkUp = 1'b1;
    step(6);
    chk(linkPinOut, 12'h000);
    chk(refClk, 12'h000);
    rstInN = 1'b1;
    step(8);
    chk(mgmtAddr, 12'h00A);
    straps = 4'h3;
    sleepIn = 1'b1;
    step(6);
    chk(pwrDown, 12'h001);
    chk(pairLane, 12'h000);
    sleepIn = 1'b0;
    step(8);
    chk(mgmtAddr, 12'h006);
    chk(pwrDown, 12'h000);
    for (int s = 0; s < 3; s++) begin
      for (int x = 0; x < 2; x++) begin
        speedSel = phycfg_pkg::phycfg_speed_t'(s);
        mdixSel = x[0];
        step(4);
        chk(pairLane, lanes(s, x[0]));
      end
    end
    rdDrive = 1'b1;
    runEn = 1'b1;
    step(500);
    runEn = 1'b0;
    step(20);
    chk(mdioOe, 12'h001);
    chk(mdioIn, 12'h000);
    rdDrive = 1'b0;
    runEn = 1'b1;
    step(500);
    runEn = 1'b0;
    step(4);
    chk(mdioOe, 12'h000);
    chk(mdioSample, 12'h001);
    linkStrap = 1'b0;
    pwrGood = 1'b0;
    step(6);
    chk(refFast, 12'h000);
    chk(linkPinOe, 12'h000);
    pwrGood = 1'b1;
    step(8);
    chk(refFast, 12'h000);
    countFlips(16, flips);
    chk(flips[11:0], 12'(16 / phycfg_pkg::REF_DIV_SLOW));
    closeOut;
  end
endmodule : phycfg_top_test
